// >>> core/sar_adc_sequencer.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps

// Contract
// - reference-connect bit isolates ladder; conversion starts only when reference connected.
// - result goes to selected pin's register; 10-bit: low 8 even, high 2 odd.
// - 8-bit result goes into even byte of selected pin's register.
// - conversion clock is base divided by 2 or 4, or undivided at high supply.
// - five modes: one-shot, repeat, single sweep, repeat sweep 0, repeat sweep 1.
// - channel mux addresses eight primary plus two extended inputs.
// - software trigger starts conversion when start flag goes to one.
// - external trigger falling edge starts, and restarts, while start flag is one.
// - without sample-and-hold, 49 cycles at 8 bits, 59 at 10 bits.
// - with sample-and-hold, 28 cycles at 8 bits, 33 at 10 bits.
// - low three control bits pick input; upper five reset to zero.
// - channel codes 010 through 111 pick inputs two through seven.
// - mode 00 one-shot, 01 repeat, 10 single sweep, 11 repeat sweeps.
// - trigger select zero means software, one means external trigger input.
// - frequency select zero divides base by four, one divides by two.
module sar_adc_sequencer
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// pins and analog front end
	input  wire logic        external_trigger_in,
	input  wire logic        cmp_above,
	output logic      [3:0]  chan_sel,
	output logic      [9:0]  sar_trial,
	output logic             sampling,
	output logic             sample_hold_en,
	output logic             vref_connect,
	output logic             busy
);

	typedef enum logic {ST_IDLE, ST_CONV} seq_e;

	typedef struct packed {
		logic [7:0]      ctrl0;
		logic [9:0]      ctrl1;
		logic [1:0]      sts;
		logic [1:0]      msk;
		logic [9:0][9:0] res;
		seq_e            st;
		logic [1:0]      divcnt;
		logic [5:0]      cnt;
		logic [3:0]      bitidx;
		logic [9:0]      trial;
		logic [3:0]      cur_ch;
		logic [2:0]      pos;
		logic            alt;
		logic            trig_s1;
		logic            trig_s2;
		logic            trig_s3;
		logic            cmp_s1;
		logic            cmp_s2;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic            irq;
		logic            sampling;
		logic            busy;
	} state_s;

	state_s r_ff;
	state_s nxt_r;

	// ======================================================
	// outputs straight from the state register
	assign prdata         = r_ff.prdata;
	assign pready         = r_ff.pready;
	assign pslverr        = r_ff.pslverr;
	assign irq            = r_ff.irq;
	assign chan_sel       = r_ff.cur_ch;
	assign sar_trial      = r_ff.trial;
	assign sampling       = r_ff.sampling;
	assign sample_hold_en = r_ff.ctrl1[SH_BIT];
	assign vref_connect   = r_ff.ctrl1[VREF_BIT];
	assign busy           = r_ff.busy;

	// ======================================================
	// next state
	always_comb begin
		// per-cycle scratch values
		logic       access;
		logic       wr_commit;
		logic       mapped;
		logic [3:0] ridx;
		logic [31:0] rdat;
		logic       tick;
		logic [5:0] tot;
		logic [5:0] nbits;
		logic [3:0] lowbit;
		logic [1:0] mode;
		logic [2:0] last_pos;
		logic [2:0] pos_inc;
		logic [3:0] single_ch;
		logic [1:0] ext;
		logic       go_old;
		logic       sw_start;
		logic       ext_start;
		logic [1:0] sts_set;
		logic [1:0] sts_clr;

		// scratch defaults, every register holds unless told otherwise
		access    = 1'b0;
		wr_commit = 1'b0;
		mapped    = 1'b0;
		ridx      = 4'h0;
		rdat      = 32'h0000_0000;
		tick      = 1'b0;
		tot       = 6'h00;
		nbits     = 6'h00;
		lowbit    = 4'h0;
		mode      = 2'h0;
		last_pos  = 3'h0;
		pos_inc   = 3'h0;
		single_ch = 4'h0;
		ext       = 2'h0;
		go_old    = 1'b0;
		sw_start  = 1'b0;
		ext_start = 1'b0;
		sts_set   = 2'h0;
		sts_clr   = 2'h0;
		nxt_r     = r_ff;

		// pin synchronisers
		nxt_r.trig_s1 = external_trigger_in;
		nxt_r.trig_s2 = r_ff.trig_s1;
		nxt_r.trig_s3 = r_ff.trig_s2;
		nxt_r.cmp_s1  = cmp_above;
		nxt_r.cmp_s2  = r_ff.cmp_s1;

		// conversion clock enable: one mclk pulse per conversion clock
		nxt_r.divcnt  = r_ff.divcnt + 2'h1;
		if (r_ff.ctrl1[FULL_BIT]) begin
			tick = 1'b1;
		end else if (r_ff.ctrl0[CKS_BIT]) begin
			tick = r_ff.divcnt[0];
		end else begin
			tick = (r_ff.divcnt == 2'h3);
		end

		// conversion length and resolution
		if (r_ff.ctrl1[RES10_BIT]) begin
			nbits  = BITS_10;
			lowbit = 4'h0;
			tot    = r_ff.ctrl1[SH_BIT] ? CYC_10_SH : CYC_10_PLAIN;
		end else begin
			nbits  = BITS_8;
			lowbit = 4'h2;
			tot    = r_ff.ctrl1[SH_BIT] ? CYC_8_SH : CYC_8_PLAIN;
		end

		// channel and mode decode
		mode     = r_ff.ctrl0[MODE_LSB +: 2];
		last_pos = {r_ff.ctrl1[SWEEP_LSB +: 2], 1'b1};
		pos_inc  = (r_ff.pos == last_pos) ? 3'h0 : r_ff.pos + 3'h1;
		ext      = r_ff.ctrl1[EXT_LSB +: 2];
		if (ext == 2'h0) begin
			single_ch = {1'b0, r_ff.ctrl0[CH_LSB +: 3]};
		end else begin
			single_ch = (ext == 2'h1) ? 4'd8 : 4'd9;
		end

		// successive approximation steps on each conversion clock
		if (r_ff.st == ST_CONV && tick) begin
			nxt_r.cnt = r_ff.cnt + 6'h01;
			// sampling over: put the top bit on trial
			if (r_ff.cnt == tot - nbits - 6'h01) begin
				nxt_r.trial    = 10'h200;
				nxt_r.bitidx   = 4'h9;
				nxt_r.sampling = 1'b0;
			end else if (r_ff.cnt >= tot - nbits) begin
				// keep or drop the bit on trial, then try the next
				nxt_r.trial[r_ff.bitidx] = r_ff.cmp_s2;
				if (r_ff.bitidx != lowbit) begin
					nxt_r.trial[r_ff.bitidx - 4'h1] = 1'b1;
				end
				nxt_r.bitidx = r_ff.bitidx - 4'h1;
			end
			if (r_ff.cnt == tot - 6'h01) begin
				// store into the selected pin's slot
				if (r_ff.ctrl1[RES10_BIT]) begin
					nxt_r.res[r_ff.cur_ch] = nxt_r.trial;
				end else begin
					nxt_r.res[r_ff.cur_ch] = {2'h0, nxt_r.trial[9:2]};
				end
				sts_set[STS_DONE_BIT] = 1'b1;
				nxt_r.cnt      = 6'h00;
				nxt_r.trial    = 10'h000;
				nxt_r.sampling = 1'b1;
				// where the sequence goes after this pin
				case (mode)
					MODE_ONESHOT: begin
						nxt_r.ctrl0[GO_BIT] = 1'b0;
						nxt_r.st            = ST_IDLE;
					end
					MODE_REPEAT: begin
						nxt_r.cur_ch = single_ch;
					end
					MODE_SWEEP: begin
						if (r_ff.pos == last_pos) begin
							sts_set[STS_SWEEP_BIT] = 1'b1;
							nxt_r.ctrl0[GO_BIT]    = 1'b0;
							nxt_r.st               = ST_IDLE;
						end else begin
							nxt_r.pos    = pos_inc;
							nxt_r.cur_ch = {1'b0, pos_inc};
						end
					end
					MODE_RSWEEP: begin
						if (r_ff.ctrl1[RS1_BIT] && !r_ff.alt) begin
							// sweep 1: selected pin between sweep pins
							nxt_r.alt    = 1'b1;
							nxt_r.cur_ch = single_ch;
						end else begin
							nxt_r.alt    = 1'b0;
							nxt_r.pos    = pos_inc;
							nxt_r.cur_ch = {1'b0, pos_inc};
							if (r_ff.pos == last_pos) begin
								sts_set[STS_SWEEP_BIT] = 1'b1;
							end
						end
					end
					default: begin
						nxt_r.st = ST_IDLE;
					end
				endcase
				if (nxt_r.st == ST_IDLE) begin
					nxt_r.sampling = 1'b0;
				end
			end
		end

		// apb: one wait cycle, then answer from registers
		access        = psel && penable;
		nxt_r.pready  = access && !r_ff.pready;
		mapped        = (paddr[1:0] == 2'h0) && (paddr <= OFS_RESULT_LAST);
		ridx          = paddr[5:2] - 4'h4;

		// read mux, narrow registers sit in the low bits
		case (paddr)
			OFS_CTRL0:  rdat = {24'h00_0000, r_ff.ctrl0};
			OFS_CTRL1:  rdat = {22'h00_0000, r_ff.ctrl1};
			OFS_STATUS: rdat = {30'h0000_0000, r_ff.sts};
			OFS_MASK:   rdat = {30'h0000_0000, r_ff.msk};
			default: begin
				if (mapped && paddr >= OFS_RESULT) begin
					rdat = {22'h00_0000, r_ff.res[ridx]};
				end
			end
		endcase

		// answer on the first access cycle, error flag stands with pready only
		if (access && !r_ff.pready) begin
			nxt_r.prdata  = pwrite ? 32'h0000_0000 : rdat;
			nxt_r.pslverr = !mapped;
		end else begin
			nxt_r.pslverr = 1'b0;
		end

		// writes land at the edge where pready is seen high
		wr_commit = access && r_ff.pready && pwrite && !r_ff.pslverr;
		go_old    = nxt_r.ctrl0[GO_BIT];
		if (wr_commit) begin
			case (paddr)
				OFS_CTRL0:  nxt_r.ctrl0 = pwdata[7:0];
				OFS_CTRL1:  nxt_r.ctrl1 = pwdata[9:0];
				OFS_STATUS: sts_clr     = pwdata[1:0];
				OFS_MASK:   nxt_r.msk   = pwdata[1:0];
				default: begin
				end
			endcase
		end

		// software stop aborts a running conversion
		if (!nxt_r.ctrl0[GO_BIT]) begin
			nxt_r.st       = ST_IDLE;
			nxt_r.sampling = 1'b0;
		end

		// start conditions
		sw_start  = !nxt_r.ctrl0[TRG_BIT] && !go_old && nxt_r.ctrl0[GO_BIT];
		ext_start = r_ff.ctrl0[TRG_BIT] && nxt_r.ctrl0[TRG_BIT] && nxt_r.ctrl0[GO_BIT]
			&& r_ff.trig_s3 && !r_ff.trig_s2;
		if ((sw_start || ext_start) && nxt_r.ctrl1[VREF_BIT]) begin
			nxt_r.st       = ST_CONV;
			nxt_r.cnt      = 6'h00;
			nxt_r.divcnt   = 2'h0;
			nxt_r.trial    = 10'h000;
			nxt_r.pos      = 3'h0;
			nxt_r.alt      = 1'b0;
			nxt_r.sampling = 1'b1;
			if (nxt_r.ctrl0[MODE_LSB +: 2] == MODE_SWEEP
				|| nxt_r.ctrl0[MODE_LSB +: 2] == MODE_RSWEEP) begin
				nxt_r.cur_ch = 4'h0;
			end else if (nxt_r.ctrl1[EXT_LSB +: 2] == 2'h0) begin
				nxt_r.cur_ch = {1'b0, nxt_r.ctrl0[CH_LSB +: 3]};
			end else begin
				nxt_r.cur_ch = (nxt_r.ctrl1[EXT_LSB +: 2] == 2'h1) ? 4'd8 : 4'd9;
			end
		end

		// sticky status, set wins over write-one-to-clear
		nxt_r.sts = (r_ff.sts & ~sts_clr) | sts_set;
		nxt_r.irq = |(nxt_r.sts & nxt_r.msk);

		// busy as its own flop so the pin comes straight from a register
		nxt_r.busy = (nxt_r.st == ST_CONV);
	end

	// ======================================================
	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// all zero, the undefined channel field included
			r_ff       <= '0;
			r_ff.ctrl0 <= CTRL0_RST;
			r_ff.ctrl1 <= CTRL1_RST;
			r_ff.sts   <= STS_RST;
			r_ff.msk   <= MSK_RST;
			r_ff.st    <= ST_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

endmodule : sar_adc_sequencer

// >>> core/adc_seq_pkg.sv
package adc_seq_pkg;

	// ======================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0       = 8'h00;
	localparam logic [7:0] OFS_CTRL1       = 8'h04;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [7:0] OFS_MASK        = 8'h0C;
	localparam logic [7:0] OFS_RESULT      = 8'h10;
	localparam logic [7:0] OFS_RESULT_LAST = 8'h34;

	// ======================================================
	// converter_ctrl_reg fields
	localparam int CH_LSB   = 0;
	localparam int MODE_LSB = 3;
	localparam int TRG_BIT  = 5;
	localparam int GO_BIT   = 6;
	localparam int CKS_BIT  = 7;

	// ======================================================
	// second control register fields
	localparam int RES10_BIT = 0;
	localparam int SH_BIT    = 1;
	localparam int VREF_BIT  = 2;
	localparam int FULL_BIT  = 3;
	localparam int SWEEP_LSB = 4;
	localparam int EXT_LSB   = 6;
	localparam int RS1_BIT   = 8;

	// ======================================================
	// status and mask bits
	localparam int STS_DONE_BIT  = 0;
	localparam int STS_SWEEP_BIT = 1;

	// ======================================================
	// values after reset
	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [9:0] CTRL1_RST = 10'h000;
	localparam logic [1:0] STS_RST   = 2'h0;
	localparam logic [1:0] MSK_RST   = 2'h0;

	// ======================================================
	// mode field codes
	localparam logic [1:0] MODE_ONESHOT = 2'h0;
	localparam logic [1:0] MODE_REPEAT  = 2'h1;
	localparam logic [1:0] MODE_SWEEP   = 2'h2;
	localparam logic [1:0] MODE_RSWEEP  = 2'h3;

	// ======================================================
	// conversion lengths in conversion clock cycles, and result widths in bits
	localparam logic [5:0] CYC_8_PLAIN  = 6'd49;
	localparam logic [5:0] CYC_10_PLAIN = 6'd59;
	localparam logic [5:0] CYC_8_SH     = 6'd28;
	localparam logic [5:0] CYC_10_SH    = 6'd33;
	localparam logic [5:0] BITS_8       = 6'd8;
	localparam logic [5:0] BITS_10      = 6'd10;

endpackage : adc_seq_pkg

// >>> test/adc_seq_assertions.sv
`timescale 1ns/100ps

// ======================================================
// port checker for the sequencer
module adc_seq_chk
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// apb and interrupt
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	// front end
	input wire logic        external_trigger_in,
	input wire logic        cmp_above,
	input wire logic [3:0]  chan_sel,
	input wire logic [9:0]  sar_trial,
	input wire logic        sampling,
	input wire logic        sample_hold_en,
	input wire logic        vref_connect,
	input wire logic        busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
	property p_ready_cause; pready |-> $past(psel && penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	property p_err_pair; pslverr |-> pready; endproperty
	a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
	property p_start_vref; $rose(busy) |-> vref_connect; endproperty
	a_start_vref: assert property (p_start_vref) else $error("start with ladder off");
	property p_chan_range; busy |-> chan_sel <= 4'h9; endproperty
	a_chan_range: assert property (p_chan_range) else $error("channel out of range");
	property p_start_sample; $rose(busy) |-> sampling; endproperty
	a_start_sample: assert property (p_start_sample) else $error("no sampling at start");
	property p_sample_busy; sampling |-> busy; endproperty
	a_sample_busy: assert property (p_sample_busy) else $error("sampling while idle");
	property p_sh_write; !$stable(sample_hold_en) |-> $past(pready && pwrite); endproperty
	a_sh_write: assert property (p_sh_write) else $error("hold enable moved alone");
	property p_vref_write; !$stable(vref_connect) |-> $past(pready && pwrite); endproperty
	a_vref_write: assert property (p_vref_write) else $error("vref moved alone");
	property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("conversion too short");
endmodule : adc_seq_chk

bind sar_adc_sequencer adc_seq_chk u_chk (.*);

// >>> test/adc_front_model.sv
`timescale 1ns/100ps

// ======================================================
// comparator, ladder and input mux
module adc_front_model (
	input  wire logic       mclk,
	input  wire logic [9:0] level,
	input  wire logic [3:0] chan_sel,
	input  wire logic [9:0] sar_trial,
	input  wire logic       vref_connect,
	output logic            cmp_above
);
	logic [9:0] vin;
	logic       flip_ff;

	// each pin sits at its own voltage
	assign vin = level + 10'(chan_sel) * 10'h029;
	always @(posedge mclk) flip_ff <= (flip_ff === 1'b0);
	// isolated ladder answers nonsense
	assign cmp_above = vref_connect ? (vin >= sar_trial) : flip_ff;
endmodule : adc_front_model

// >>> test/tb_sar_adc_sequencer.sv
`timescale 1ns/100ps

module tb_sar_adc_sequencer;
	import adc_seq_pkg::*;
	logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, ext_trig, cmp, smp, she;
	logic vref, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] chs;
	logic [9:0] trial, level;
	logic e;
	int failures, comparisons, cyc, n, dv;
	logic [31:0] seed;

	sar_adc_sequencer DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .external_trigger_in(ext_trig), .cmp_above(cmp),
		.chan_sel(chs), .sar_trial(trial), .sampling(smp), .sample_hold_en(she),
		.vref_connect(vref), .busy(busy));
	adc_front_model u_front (.mclk(mclk), .level(level), .chan_sel(chs), .sar_trial(trial),
		.vref_connect(vref), .cmp_above(cmp));

	// ======================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] exp_res(input logic [9:0] lv, input int ch, input logic b10);
		logic [9:0] v;
		v = lv + 10'(ch) * 10'h029;
		return b10 ? {22'h0, v} : {24'h0, v[9:2]};
	endfunction : exp_res
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
		comparisons++;
		if (seen !== expv) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, expv, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin @(posedge mclk); end while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic run();
		cyc = 0;
		do begin @(posedge mclk); cyc++; end while (busy !== 1'b1 && cyc < 40);
		chk("run_start", 32'(busy), 1);
		while (busy === 1'b1 && cyc < 3000) begin @(posedge mclk); cyc++; end
		chk("run_end", 32'(busy), 0);
	endtask : run
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize

	// ======================================================
	// clock and watchdog
	initial begin mclk = 1'b0; forever #10 mclk = ~mclk; end
	initial begin #1200000; failures++; summarize(); end

	// ======================================================
	// tests
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ext_trig = 1'b1; level = 10'h0; seed = 32'h4375; failures = 0; comparisons = 0;
		sys_rst = 1'b1;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin apb(0, 8'(4 * i), 0); chk("reset_reg", r, 0); end
		apb(0, 8'h40, 0); chk("unmapped_err", 32'(e), 1);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			level <= seed[25:16];
			apb(1, OFS_MASK, 32'(i != 5));
			apb(1, OFS_CTRL1, {24'h0, i < 8 ? 2'h0 : 2'(i - 7), 4'h1, seed[4:3]});
			apb(1, OFS_CTRL0, {24'h0, i == 3, 4'h8, i < 8 ? 3'(i) : 3'h0});
			run();
			n = seed[3] ? (seed[4] ? 33 : 59) : (seed[4] ? 28 : 49);
			chk("hold_en", 32'(she), 32'(seed[4]));
			dv = (i == 3) ? 2 : 4;
			chk("cycles", 32'(cyc >= n * dv - dv && cyc <= n * dv + dv + 4), 1);
			apb(0, 8'(OFS_RESULT + 4 * i), 0);
			if (i != 3) chk("result", r, exp_res(level, i, seed[3]));
			chk("irq", 32'(irq), 32'(i != 5));
			apb(0, OFS_CTRL0, 0); chk("go_clear", 32'(r[GO_BIT]), 0);
			apb(1, OFS_STATUS, 3);
			repeat (2) @(posedge mclk);
			chk("irq_clear", 32'(irq), 0);
		end
		$display("test one-shot done");
		apb(1, OFS_CTRL1, 0); apb(1, OFS_CTRL0, 8'h40);
		repeat (20) @(posedge mclk);
		chk("no_start", 32'(busy), 0);
		apb(1, OFS_CTRL0, 0); apb(1, OFS_CTRL1, 4); apb(1, OFS_CTRL0, 8'h60);
		repeat (20) @(posedge mclk);
		chk("wait_trigger", 32'(busy), 0);
		ext_trig <= 1'b0;
		repeat (60) @(posedge mclk);
		ext_trig <= 1'b1;
		repeat (3) @(posedge mclk);
		ext_trig <= 1'b0;
		run();
		chk("retrigger", 32'(cyc >= 49 * 4 - 8), 1);
		apb(0, OFS_RESULT, 0); chk("ext_result", r, exp_res(level, 0, 1'b0));
		ext_trig <= 1'b1;
		$display("test trigger done");
		for (int m = 1; m < 4; m += 2) begin
			// second pass runs repeat sweep 1
			apb(1, OFS_CTRL1, 32'(m == 3 ? 10'h104 : 10'h004));
			apb(1, OFS_CTRL0, 32'(8'h40 | (m << 3)));
			repeat (300) @(posedge mclk);
			chk("repeat_busy", 32'(busy), 1);
			apb(1, OFS_CTRL0, 0);
			repeat (5) @(posedge mclk);
			chk("abort", 32'(busy), 0);
		end
		apb(1, OFS_CTRL0, 8'h50);
		run();
		apb(0, OFS_RESULT + 8'h04, 0); chk("sweep_result", r, exp_res(level, 1, 1'b0));
		apb(0, OFS_CTRL0, 0); chk("sweep_stop", 32'(r[GO_BIT]), 0);
		apb(0, OFS_STATUS, 0); chk("sweep_status", r, 3);
		$display("test modes done");
		summarize();
	end
endmodule : tb_sar_adc_sequencer
